// File: rtl/late_write_consts.vh
// Constants for the late-write synchronous static RAM port.
// Assumes inclusion by every design file of the block; no other file defines these names.
//
// What this block does
// - Wide build holds 32K words of 36 bits; narrow build 64K words of 18.
// - Each true clock rising edge captures address, write enable, byte enables, chip select.
// - Write data arrives one clock edge after its address; device buffers and commits it.
// - Read data is launched onto the data pins on a rising clock edge only.
// - A write updates any chosen subset of byte lanes, or the whole word.
// - Clock is a true/complement pair; the true rising edge is the sampling edge.
// - Output enable is asynchronous, active low; deasserted means data pins are not driven.
// - Chip select is active low, sampled on the edge; only low starts an access.
// - Write enable sampled low makes a write of every enabled byte lane.
// - Byte enables act only with write enable; reads ignore them and return the full word.
`ifndef LATE_WRITE_CONSTS_VH
`define LATE_WRITE_CONSTS_VH

`define WIDE_DATA_W 36
`define WIDE_ADDR_W 15
`define WIDE_LANES 4
`define NARROW_DATA_W 18
`define NARROW_ADDR_W 16
`define NARROW_LANES 2
`define LANE_W 9

`define WR_FIFO_DEPTH 8
`define WR_FIFO_PTR_W 3

`define SEL_ACTIVE 1'h0
`define WR_ACTIVE 1'h0
`define OE_ACTIVE 1'h0

`endif

// File: rtl/write_fifo.v
// Synchronous FIFO carrying committed write words toward the storage array.
// Assumes one clock, synchronous active-low reset, depth a power of two.
`timescale 1ns/1ps
`include "late_write_consts.vh"

module write_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = `WR_FIFO_DEPTH,
	parameter PW = `WR_FIFO_PTR_W
) (
	input wire clk,
	input wire resetn,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [PW-1:0] wr_ptr_ff;
	reg [PW-1:0] rd_ptr_ff;
	reg [PW:0] count_ff;
	wire push;
	wire pop;

	assign in_ready = (count_ff != DEPTH[PW:0]);
	assign out_valid = (count_ff != {(PW+1){1'b0}});
	assign out_data = mem[rd_ptr_ff];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_ff] <= in_data;
		end
	end

	always @(posedge clk) begin
		if (!resetn) begin
			wr_ptr_ff <= {PW{1'b0}};
			rd_ptr_ff <= {PW{1'b0}};
			count_ff <= {(PW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			end
			if (push && !pop) begin
				count_ff <= count_ff + 1'b1;
			end else if (pop && !push) begin
				count_ff <= count_ff - 1'b1;
			end
		end
	end
endmodule

// File: rtl/sram_store.v
// Storage array with byte-lane write and registered read.
// Assumes the caller never asks for a read and a write in the same cycle.
`timescale 1ns/1ps
`include "late_write_consts.vh"

module sram_store #(
	parameter AW = `WIDE_ADDR_W,
	parameter DW = `WIDE_DATA_W,
	parameter NB = `WIDE_LANES
) (
	input wire clk,
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [NB-1:0] wr_lane_en,
	input wire [DW-1:0] wr_data,
	input wire rd_en,
	input wire [AW-1:0] rd_addr,
	output reg [DW-1:0] rd_data
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	genvar i;
	generate
		for (i = 0; i < NB; i = i + 1) begin : g_lane
			always @(posedge clk) begin
				if (wr_en && wr_lane_en[i]) begin
					mem[wr_addr][i*`LANE_W +: `LANE_W] <= wr_data[i*`LANE_W +: `LANE_W];
				end
			end
		end
	endgenerate

	always @(posedge clk) begin
		if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule

// File: rtl/late_write_sync_sram_port.v
// Late-write synchronous static RAM port: pin-side pipeline, write buffer and array.
// Assumes the pin clock pair runs well below clk, each half period at least
// three clk cycles, so every pin edge is seen and a read completes before the next edge.
`timescale 1ns/1ps
`include "late_write_consts.vh"

module late_write_sync_sram_port #(
	parameter WIDE = 1
) (
	clk,
	resetn,
	diff_clk_pair_t,
	diff_clk_pair_c,
	sync_addr_in,
	chip_sel_n,
	write_en_n,
	byte_write_en_n,
	out_en_n,
	data_io_lane_in,
	data_io_lane_out,
	data_io_lane_oe_n,
	write_stall,
	read_late
);
	localparam DW = WIDE ? `WIDE_DATA_W : `NARROW_DATA_W;
	localparam AW = WIDE ? `WIDE_ADDR_W : `NARROW_ADDR_W;
	localparam NB = WIDE ? `WIDE_LANES : `NARROW_LANES;
	localparam EW = AW + NB + DW;

	input wire clk;
	input wire resetn;
	input wire diff_clk_pair_t;
	input wire diff_clk_pair_c;
	input wire [AW-1:0] sync_addr_in;
	input wire chip_sel_n;
	input wire write_en_n;
	input wire [NB-1:0] byte_write_en_n;
	input wire out_en_n;
	input wire [DW-1:0] data_io_lane_in;
	output wire [DW-1:0] data_io_lane_out;
	output wire [DW-1:0] data_io_lane_oe_n;
	output wire write_stall;
	output wire read_late;

	// Pin synchronisers, first stage
	reg ck_t_s1_ff;
	reg ck_c_s1_ff;
	reg [AW-1:0] addr_s1_ff;
	reg sel_n_s1_ff;
	reg wr_n_s1_ff;
	reg [NB-1:0] be_n_s1_ff;
	reg [DW-1:0] dq_s1_ff;

	// Second stage, the first that logic reads
	reg ck_t_s2_ff;
	reg ck_c_s2_ff;
	reg [AW-1:0] addr_s2_ff;
	reg sel_n_s2_ff;
	reg wr_n_s2_ff;
	reg [NB-1:0] be_n_s2_ff;
	reg [DW-1:0] dq_s2_ff;

	// Edge detector history
	reg ck_t_s3_ff;
	reg ck_c_s3_ff;
	wire pin_rise;

	// Input registers loaded on each sampling edge
	reg [AW-1:0] cap_addr_ff;
	reg cap_sel_n_ff;
	reg cap_wr_n_ff;
	reg [NB-1:0] cap_be_n_ff;

	// Access tracking between pin edges
	reg wr_slot_ff;
	reg [AW-1:0] wr_addr_ff;
	reg [NB-1:0] wr_lanes_ff;
	reg rd_slot_ff;
	reg rd_pend_ff;
	reg [AW-1:0] rd_addr_ff;
	reg rd_wait_ff;
	reg rd_done_ff;
	reg [DW-1:0] rd_hold_ff;
	reg late_ff;

	// Pin output side
	reg [DW-1:0] dq_out_ff;
	reg drive_ff;

	// Write buffer and array
	wire acc_sel;
	wire acc_write;
	wire acc_read;
	wire push_valid;
	wire push_ready;
	wire [EW-1:0] push_data;
	wire pop_valid;
	wire pop_ready;
	wire [EW-1:0] pop_data;
	wire rd_issue;
	wire [DW-1:0] arr_rd_data;
	wire store_wr_en;
	wire [AW-1:0] store_wr_addr;
	wire [NB-1:0] store_wr_lanes;
	wire [DW-1:0] store_wr_data;

	// Pin clock history resets high, so a pin held high through reset gives no edge
	always @(posedge clk) begin
		if (!resetn) begin
			ck_t_s1_ff <= 1'h1;
			ck_c_s1_ff <= 1'h0;
			addr_s1_ff <= {AW{1'b0}};
			sel_n_s1_ff <= 1'h1;
			wr_n_s1_ff <= 1'h1;
			be_n_s1_ff <= {NB{1'b1}};
			dq_s1_ff <= {DW{1'b0}};
		end else begin
			ck_t_s1_ff <= diff_clk_pair_t;
			ck_c_s1_ff <= diff_clk_pair_c;
			addr_s1_ff <= sync_addr_in;
			sel_n_s1_ff <= chip_sel_n;
			wr_n_s1_ff <= write_en_n;
			be_n_s1_ff <= byte_write_en_n;
			dq_s1_ff <= data_io_lane_in;
		end
	end

	always @(posedge clk) begin
		if (!resetn) begin
			ck_t_s2_ff <= 1'h1;
			ck_c_s2_ff <= 1'h0;
			addr_s2_ff <= {AW{1'b0}};
			sel_n_s2_ff <= 1'h1;
			wr_n_s2_ff <= 1'h1;
			be_n_s2_ff <= {NB{1'b1}};
			dq_s2_ff <= {DW{1'b0}};
		end else begin
			ck_t_s2_ff <= ck_t_s1_ff;
			ck_c_s2_ff <= ck_c_s1_ff;
			addr_s2_ff <= addr_s1_ff;
			sel_n_s2_ff <= sel_n_s1_ff;
			wr_n_s2_ff <= wr_n_s1_ff;
			be_n_s2_ff <= be_n_s1_ff;
			dq_s2_ff <= dq_s1_ff;
		end
	end

	always @(posedge clk) begin
		if (!resetn) begin
			ck_t_s3_ff <= 1'h1;
			ck_c_s3_ff <= 1'h0;
		end else begin
			ck_t_s3_ff <= ck_t_s2_ff;
			ck_c_s3_ff <= ck_c_s2_ff;
		end
	end

	// Complement must have been high while true was low; tolerates a lagging complement
	assign pin_rise = ck_t_s2_ff & ~ck_t_s3_ff & ck_c_s3_ff;

	// Every sampling edge loads the input registers, selected or not
	always @(posedge clk) begin
		if (!resetn) begin
			cap_addr_ff <= {AW{1'b0}};
			cap_sel_n_ff <= 1'h1;
			cap_wr_n_ff <= 1'h1;
			cap_be_n_ff <= {NB{1'b1}};
		end else if (pin_rise) begin
			cap_addr_ff <= addr_s2_ff;
			cap_sel_n_ff <= sel_n_s2_ff;
			cap_wr_n_ff <= wr_n_s2_ff;
			cap_be_n_ff <= be_n_s2_ff;
		end
	end

	assign acc_sel = (sel_n_s2_ff == `SEL_ACTIVE);
	assign acc_write = acc_sel & (wr_n_s2_ff == `WR_ACTIVE);
	assign acc_read = acc_sel & (wr_n_s2_ff != `WR_ACTIVE);

	// Write slot: the edge after a selected write carries its data
	always @(posedge clk) begin
		if (!resetn) begin
			wr_slot_ff <= 1'h0;
			wr_addr_ff <= {AW{1'b0}};
			wr_lanes_ff <= {NB{1'b0}};
		end else if (pin_rise) begin
			wr_slot_ff <= acc_write;
			wr_addr_ff <= addr_s2_ff;
			wr_lanes_ff <= ~be_n_s2_ff;
		end
	end

	// Data at the slot edge joins the address from the previous edge
	assign push_valid = pin_rise & wr_slot_ff;
	assign push_data = {wr_addr_ff, wr_lanes_ff, dq_s2_ff};
	assign write_stall = ~push_ready;

	write_fifo #(
		.WIDTH(EW),
		.DEPTH(`WR_FIFO_DEPTH),
		.PW(`WR_FIFO_PTR_W)
	) u_write_fifo (
		.clk(clk),
		.resetn(resetn),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.in_data(push_data),
		.out_valid(pop_valid),
		.out_ready(pop_ready),
		.out_data(pop_data)
	);

	// Reads wait for the buffer to empty, so a read always sees earlier writes
	assign rd_issue = rd_pend_ff & ~pop_valid;
	assign pop_ready = ~rd_issue;

	// Buffered entry fields: address, lane mask, then data in the low bits
	assign store_wr_en = pop_valid & pop_ready;
	assign store_wr_addr = pop_data[EW-1 -: AW];
	assign store_wr_lanes = pop_data[DW +: NB];
	assign store_wr_data = pop_data[DW-1:0];

	sram_store #(
		.AW(AW),
		.DW(DW),
		.NB(NB)
	) u_sram_store (
		.clk(clk),
		.wr_en(store_wr_en),
		.wr_addr(store_wr_addr),
		.wr_lane_en(store_wr_lanes),
		.wr_data(store_wr_data),
		.rd_en(rd_issue),
		.rd_addr(rd_addr_ff),
		.rd_data(arr_rd_data)
	);

	// Read request bookkeeping
	always @(posedge clk) begin
		if (!resetn) begin
			rd_pend_ff <= 1'h0;
			rd_addr_ff <= {AW{1'b0}};
		end else if (pin_rise && acc_read) begin
			rd_pend_ff <= 1'h1;
			rd_addr_ff <= addr_s2_ff;
		end else if (rd_issue) begin
			rd_pend_ff <= 1'h0;
		end
	end

	always @(posedge clk) begin
		if (!resetn) begin
			rd_wait_ff <= 1'h0;
		end else begin
			rd_wait_ff <= rd_issue;
		end
	end

	// Word held until the launch edge; a new read discards a stale one
	always @(posedge clk) begin
		if (!resetn) begin
			rd_done_ff <= 1'h0;
			rd_hold_ff <= {DW{1'b0}};
		end else if (rd_wait_ff) begin
			rd_done_ff <= 1'h1;
			rd_hold_ff <= arr_rd_data;
		end else if (pin_rise) begin
			rd_done_ff <= 1'h0;
		end
	end

	always @(posedge clk) begin
		if (!resetn) begin
			rd_slot_ff <= 1'h0;
		end else if (pin_rise) begin
			rd_slot_ff <= acc_read;
		end
	end

	// Launch on the edge after capture; pins released otherwise
	always @(posedge clk) begin
		if (!resetn) begin
			dq_out_ff <= {DW{1'b0}};
			drive_ff <= 1'h0;
		end else if (pin_rise) begin
			drive_ff <= rd_slot_ff;
			if (rd_slot_ff) begin
				dq_out_ff <= rd_hold_ff;
			end
		end
	end

	// Pin clock too fast for the array: word was not ready at launch
	always @(posedge clk) begin
		if (!resetn) begin
			late_ff <= 1'h0;
		end else begin
			late_ff <= pin_rise & rd_slot_ff & ~rd_done_ff;
		end
	end

	assign read_late = late_ff;
	assign data_io_lane_out = dq_out_ff;
	// Asynchronous gate straight from the pin, bypassing the synchronisers
	assign data_io_lane_oe_n = {DW{(out_en_n != `OE_ACTIVE) | ~drive_ff}};
endmodule

// File: verification/late_write_sync_sram_port_asserts.sv
// Checker on the pin side of the late-write port.
// Assumes pin half periods of several clk cycles, complement pin the inverse of true.
`timescale 1ns/1ps
`include "late_write_consts.vh"

module late_write_sync_sram_port_asserts #(
	parameter WIDE = 1,
	parameter DW = WIDE ? `WIDE_DATA_W : `NARROW_DATA_W
) (
	input wire clk,
	input wire resetn,
	input wire diff_clk_pair_t,
	input wire chip_sel_n,
	input wire write_en_n,
	input wire out_en_n,
	input wire [DW-1:0] data_io_lane_out,
	input wire [DW-1:0] data_io_lane_oe_n,
	input wire write_stall,
	input wire read_late
);
	reg [2:0] pin_ff;
	reg rd_prev_ff;
	reg [3:0] since_ff;
	wire ed;
	assign ed = pin_ff[1] & ~pin_ff[2];
	// Own copy of the pin edge, so slips in the design's detector show up
	always @(posedge clk) begin
		if (!resetn) begin
			pin_ff <= 3'h7;
			rd_prev_ff <= 1'h0;
			since_ff <= 4'hF;
		end else begin
			pin_ff <= {pin_ff[1:0], diff_clk_pair_t};
			if (ed) begin
				rd_prev_ff <= !chip_sel_n && write_en_n;
				since_ff <= 4'h0;
			end else if (since_ff != 4'hF) begin
				since_ff <= since_ff + 4'h1;
			end
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_read_edge;
		ed && rd_prev_ff && !out_en_n;
	endsequence
	sequence s_drive_on;
		##[1:5] (!data_io_lane_oe_n[0] || out_en_n);
	endsequence
	AST_OE_GATE: assert property (out_en_n |-> &data_io_lane_oe_n)
		else $error("pins driven with output enable off");
	AST_OE_UNIFORM: assert property (&data_io_lane_oe_n || !(|data_io_lane_oe_n))
		else $error("output enables differ between bits");
	AST_DATA_SYNC: assert property (!$stable(data_io_lane_out) |-> since_ff <= 4'h4)
		else $error("read data moved away from a pin edge");
	AST_DRIVE_SYNC: assert property ($fell(data_io_lane_oe_n[0]) && $past(!out_en_n)
		|-> since_ff <= 4'h4) else $error("drive began away from a pin edge");
	AST_READ_DRIVE: assert property (s_read_edge |-> s_drive_on)
		else $error("read word not driven at the next edge");
	AST_IDLE_RELEASE: assert property (ed && !rd_prev_ff |-> ##6 data_io_lane_oe_n[0])
		else $error("pins driven after a non-read edge");
	AST_RESET_QUIET: assert property ($rose(resetn) |-> &data_io_lane_oe_n
		&& data_io_lane_out == '0 && !write_stall && !read_late) else $error("busy out of reset");
	AST_LATE_PULSE: assert property (read_late |=> !read_late)
		else $error("late flag longer than a cycle");
endmodule

bind late_write_sync_sram_port late_write_sync_sram_port_asserts #(.WIDE(WIDE)) chk_i (
	.clk(clk), .resetn(resetn), .diff_clk_pair_t(diff_clk_pair_t), .chip_sel_n(chip_sel_n),
	.write_en_n(write_en_n), .out_en_n(out_en_n), .data_io_lane_out(data_io_lane_out),
	.data_io_lane_oe_n(data_io_lane_oe_n), .write_stall(write_stall), .read_late(read_late)
);

// File: verification/pin_ctrl_model.sv
// Memory controller model: pin clock pair, address, controls and late write data.
// Assumes clk is the bench clock; each pin period spans twelve clk cycles, five low and seven high.
`timescale 1ns/1ps
`include "late_write_consts.vh"

module pin_ctrl_model (
	input wire clk,
	output logic pin_t,
	output logic pin_c,
	output logic [`WIDE_ADDR_W-1:0] addr,
	output logic sel_n,
	output logic wr_n,
	output logic [`WIDE_LANES-1:0] lane_n,
	output logic [`WIDE_DATA_W-1:0] wdata
);
	logic pend;
	logic [`WIDE_DATA_W-1:0] pend_data;
	initial begin
		pin_t = 1'h0;
		pin_c = 1'h1;
		addr = '0;
		sel_n = 1'h1;
		wr_n = 1'h1;
		lane_n = '1;
		wdata = '0;
		pend = 1'h0;
		pend_data = '0;
	end
	// One pin period; write data d goes out in the following period
	task cyc(input logic s, input logic w, input logic [`WIDE_LANES-1:0] b,
		input logic [`WIDE_ADDR_W-1:0] a, input logic [`WIDE_DATA_W-1:0] d);
		begin
			@(posedge clk);
			#1;
			pin_t = 1'h0;
			pin_c = 1'h1;
			sel_n = s;
			wr_n = w;
			lane_n = b;
			addr = a;
			// Off-slot data flips so stale values never look valid
			wdata = pend ? pend_data : ~wdata;
			pend = !w;
			pend_data = d;
			repeat (5) @(posedge clk);
			#1;
			pin_t = 1'h1;
			pin_c = 1'h0;
			repeat (6) @(posedge clk);
			#2;
		end
	endtask
endmodule

// File: verification/late_write_sync_sram_port_tb_top.sv
// Bench for the late-write port: write/read-back rows, then hand-written cases.
// Assumes the wide build and the controller model in place of the far side.
`timescale 1ns/1ps
`include "late_write_consts.vh"

module late_write_sync_sram_port_tb_top;
	typedef struct packed {logic [14:0] a; logic [3:0] b; logic [35:0] d; logic [35:0] e;} row_t;
	logic clk = 1'h0;
	logic resetn = 1'h0;
	logic out_en_n = 1'h0;
	wire pin_t, pin_c, sel_n, wr_n, write_stall, read_late;
	wire [14:0] addr;
	wire [3:0] lane_n;
	wire [35:0] wdata, rdata, oe_n;
	int err_total = 0;
	int samples_checked = 0;
	int cycles = 0;
	row_t rows [6] = '{
		'{15'h0000, 4'h0, 36'h123456789, 36'h123456789},
		'{15'h0000, 4'hE, 36'hFFFFFFFFF, 36'h1234567FF},
		'{15'h7FFF, 4'h0, 36'hABCDEF012, 36'hABCDEF012},
		'{15'h7FFF, 4'h7, 36'h000000000, 36'h004DEF012},
		'{15'h7FFF, 4'hF, 36'hFFFFFFFFF, 36'h004DEF012},
		'{15'h0000, 4'h5, 36'h000000000, 36'h0034401FF}};

	pin_ctrl_model ctl (.clk(clk), .pin_t(pin_t), .pin_c(pin_c), .addr(addr), .sel_n(sel_n),
		.wr_n(wr_n), .lane_n(lane_n), .wdata(wdata));
	late_write_sync_sram_port #(.WIDE(1)) DUT (.clk(clk), .resetn(resetn),
		.diff_clk_pair_t(pin_t), .diff_clk_pair_c(pin_c), .sync_addr_in(addr),
		.chip_sel_n(sel_n), .write_en_n(wr_n), .byte_write_en_n(lane_n), .out_en_n(out_en_n),
		.data_io_lane_in(wdata), .data_io_lane_out(rdata), .data_io_lane_oe_n(oe_n),
		.write_stall(write_stall), .read_late(read_late));

	always #12.5 clk = ~clk;

	task chk(input logic [35:0] seen, input logic [35:0] exp);
		begin
			samples_checked++;
			if (seen !== exp) begin
				err_total++;
				$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
			end
		end
	endtask
	// Read with every byte enable asserted, then look one edge later
	task rd(input logic [14:0] a, input logic [35:0] e);
		begin
			ctl.cyc(1'h0, 1'h1, 4'h0, a, 36'h0);
			ctl.cyc(1'h1, 1'h1, 4'hF, 15'h0, 36'h0);
			chk(rdata, e);
			chk(oe_n, 36'h0);
		end
	endtask
	task results;
		begin
			$display("checks %0d mismatches %0d", samples_checked, err_total);
			if (err_total == 0 && samples_checked > 0) begin
				$display("bench passed");
			end else begin
				$display("bench failed");
			end
			$finish;
		end
	endtask
	// A normal run is under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			results;
		end
	end

	initial begin
		repeat (3) @(posedge clk);
		#1;
		chk(oe_n, {36{1'h1}});
		chk(rdata, 36'h0);
		chk(36'({write_stall, read_late}), 36'h0);
		resetn = 1'h1;
		$display("reset test done");
		repeat (4) @(posedge clk);
		foreach (rows[i]) begin
			ctl.cyc(1'h0, 1'h0, rows[i].b, rows[i].a, rows[i].d);
			ctl.cyc(1'h1, 1'h1, 4'hF, 15'h0, 36'h0);
			rd(rows[i].a, rows[i].e);
		end
		$display("row tests done");
		ctl.cyc(1'h0, 1'h0, 4'h0, 15'h0002, 36'h111111111);
		ctl.cyc(1'h0, 1'h0, 4'h0, 15'h0003, 36'h222222222);
		ctl.cyc(1'h0, 1'h1, 4'h0, 15'h0002, 36'h0);
		ctl.cyc(1'h0, 1'h1, 4'h0, 15'h0003, 36'h0);
		chk(rdata, 36'h111111111);
		ctl.cyc(1'h1, 1'h1, 4'hF, 15'h0, 36'h0);
		chk(rdata, 36'h222222222);
		@(posedge clk);
		#1;
		out_en_n = 1'h1;
		#1;
		chk(oe_n, {36{1'h1}});
		@(posedge clk);
		#1;
		out_en_n = 1'h0;
		#1;
		chk(oe_n, 36'h0);
		$display("back to back test done");
		ctl.cyc(1'h1, 1'h0, 4'h0, 15'h0002, 36'h0);
		ctl.cyc(1'h1, 1'h1, 4'hF, 15'h0, 36'h0);
		chk(oe_n, {36{1'h1}});
		rd(15'h0002, 36'h111111111);
		chk(36'(write_stall), 36'h0);
		$display("deselect test done");
		// Reset with a selected read left on the pins and the pin clock held high
		ctl.cyc(1'h0, 1'h1, 4'h0, 15'h0002, 36'h0);
		@(posedge clk);
		#1;
		resetn = 1'h0;
		repeat (3) @(posedge clk);
		#1;
		chk(oe_n, {36{1'h1}});
		chk(rdata, 36'h0);
		chk(36'({write_stall, read_late}), 36'h0);
		resetn = 1'h1;
		repeat (4) @(posedge clk);
		ctl.cyc(1'h1, 1'h1, 4'hF, 15'h0, 36'h0);
		chk(oe_n, {36{1'h1}});
		ctl.cyc(1'h0, 1'h0, 4'h0, 15'h0004, 36'h5A5A5A5A5);
		ctl.cyc(1'h1, 1'h1, 4'hF, 15'h0, 36'h0);
		rd(15'h0004, 36'h5A5A5A5A5);
		$display("mid-run reset test done");
		results;
	end
endmodule
